// ===== verilog/prmc_top.sv
// power rail mode control: axi4-lite register file and rail enables
//
// Overview of operation
// - hibernation clamp uses lower rail; select-off bit forces high rail
// - converter stops when system domain is down, restarts when it returns
// - after reset the tie resistor control selects diodes, switch open
// - tie control 0x2 with core retention ties rails during sleep
// - tie control 0x3 with comparator and retention ties rails near 50 mV
// - boost converter defaults 1.8 V, selectable 2.5 V or 3.0 V
// - masked high-rail detector: status readable, no reset
// - disabled high-rail detector: no reset, status unavailable
// - shorted rails are identified as boost configuration
`timescale 1ns/100ps
module prmc_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire prmc_pkg::prmc_mode_t power_mode,
  input wire logic system_domain_up,
  input wire logic boost_detected,
  input wire logic high_near_low,
  input wire logic por_high_raw,
  output logic clamp_from_high_ff,
  output logic [3:0] clamp_trim_ff,
  output logic converter_run_ff,
  output logic [1:0] converter_level_ff,
  output logic [1:0] low_regulator_mode_ff,
  output logic core_retention_ff,
  output logic high_comparator_ff,
  output logic rail_tie_switch_ff,
  output logic por_high_reset_ff,
  output logic boost_mode_ff
);
  // ---------------------------------------------------------------
  // control register fields and status
  // ---------------------------------------------------------------
  logic [1:0] tie_res_ff;
  logic clamp_sel_off_ff;
  logic por_mask_ff;
  logic [3:0] trim_ff;
  logic core_ret_ff;
  logic [1:0] low_reg_ff;
  logic hi_cmp_ff;
  logic por_dis_ff;
  logic tie_sw_ff;
  logic conv_on_ff;
  logic [1:0] conv_sel_ff;
  logic boost_seen_ff;
  logic por_status;
  logic por_status_valid;
  prmc_if cfg ();

  // ---------------------------------------------------------------
  // axi4-lite handshake
  // ---------------------------------------------------------------
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic do_write;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == prmc_pkg::ALWAYS_ON_POWER_CONTROL_OFS) ||
      (a == prmc_pkg::POWER_CONTROL_OFS) || (a == prmc_pkg::CONVERTER_CONTROL_OFS) ||
      (a == prmc_pkg::POWER_LEVEL_OFS) || (a == prmc_pkg::RAIL_STATUS_OFS);
  endfunction

  assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= prmc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok(aw_addr_ff) ? prmc_pkg::RESP_OKAY : prmc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tie_res_ff <= prmc_pkg::TIE_RES_DIODE;
      clamp_sel_off_ff <= 1'b0;
      por_mask_ff <= 1'b0;
      trim_ff <= prmc_pkg::TRIM_RST;
      core_ret_ff <= 1'b0;
      low_reg_ff <= prmc_pkg::LOW_REG_RST;
      hi_cmp_ff <= 1'b0;
      por_dis_ff <= 1'b0;
      tie_sw_ff <= 1'b0;
      conv_on_ff <= 1'b0;
      conv_sel_ff <= prmc_pkg::LVL_1V8;
    end else if (do_write) begin // fields held until rewritten
      case (aw_addr_ff)
        prmc_pkg::ALWAYS_ON_POWER_CONTROL_OFS: begin
          if (w_strb_ff[0]) begin
            tie_res_ff <= w_data_ff[prmc_pkg::AON_TIE_RES_LSB +: 2];
            clamp_sel_off_ff <= w_data_ff[prmc_pkg::AON_CLAMP_SEL_OFF_BIT];
            por_mask_ff <= w_data_ff[prmc_pkg::AON_POR_MASK_BIT];
            trim_ff <= w_data_ff[prmc_pkg::AON_TRIM_LSB +: 4];
          end
          if (w_strb_ff[1]) begin
            core_ret_ff <= w_data_ff[prmc_pkg::AON_CORE_RET_BIT];
          end
        end
        prmc_pkg::POWER_CONTROL_OFS: begin
          if (w_strb_ff[0]) begin
            low_reg_ff <= w_data_ff[prmc_pkg::PWR_LOW_REG_LSB +: 2];
            core_ret_ff <= w_data_ff[prmc_pkg::PWR_CORE_RET_BIT];
            hi_cmp_ff <= w_data_ff[prmc_pkg::PWR_HI_CMP_BIT];
            por_dis_ff <= w_data_ff[prmc_pkg::PWR_POR_DIS_BIT];
            tie_sw_ff <= w_data_ff[prmc_pkg::PWR_TIE_SW_BIT];
          end
        end
        prmc_pkg::CONVERTER_CONTROL_OFS: begin
          if (w_strb_ff[0]) begin
            conv_on_ff <= w_data_ff[prmc_pkg::CNV_ON_BIT];
          end
        end
        prmc_pkg::POWER_LEVEL_OFS: begin
          if (w_strb_ff[0]) begin
            conv_sel_ff <= w_data_ff[prmc_pkg::LVL_SEL_LSB +: 2];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // boost identification resampled every cycle after reset release
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      boost_seen_ff <= 1'b0;
    end else begin
      boost_seen_ff <= boost_detected; // shorted rails read as boost
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = 32'h00000000;
    case (a)
      prmc_pkg::ALWAYS_ON_POWER_CONTROL_OFS: begin
        read_word[prmc_pkg::AON_TIE_RES_LSB +: 2] = tie_res_ff;
        read_word[prmc_pkg::AON_CLAMP_SEL_OFF_BIT] = clamp_sel_off_ff;
        read_word[prmc_pkg::AON_POR_MASK_BIT] = por_mask_ff;
        read_word[prmc_pkg::AON_TRIM_LSB +: 4] = trim_ff;
        read_word[prmc_pkg::AON_CORE_RET_BIT] = core_ret_ff;
      end
      prmc_pkg::POWER_CONTROL_OFS: begin
        read_word[prmc_pkg::PWR_LOW_REG_LSB +: 2] = low_reg_ff;
        read_word[prmc_pkg::PWR_CORE_RET_BIT] = core_ret_ff;
        read_word[prmc_pkg::PWR_HI_CMP_BIT] = hi_cmp_ff;
        read_word[prmc_pkg::PWR_POR_DIS_BIT] = por_dis_ff;
        read_word[prmc_pkg::PWR_TIE_SW_BIT] = tie_sw_ff;
      end
      prmc_pkg::CONVERTER_CONTROL_OFS: read_word[prmc_pkg::CNV_ON_BIT] = conv_on_ff;
      prmc_pkg::POWER_LEVEL_OFS: read_word[prmc_pkg::LVL_SEL_LSB +: 2] = conv_sel_ff;
      prmc_pkg::RAIL_STATUS_OFS: begin
        read_word[0] = por_status;
        read_word[1] = por_status_valid;
        read_word[2] = boost_seen_ff;
        read_word[3] = converter_run_ff;
        read_word[4] = rail_tie_switch_ff;
      end
      default: read_word = 32'h00000000;
    endcase
  endfunction

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= prmc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word(s_axi_araddr);
        s_axi_rresp <= addr_ok(s_axi_araddr) ? prmc_pkg::RESP_OKAY : prmc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // rail enables
  // ---------------------------------------------------------------
  assign cfg.tie_res_ctrl = tie_res_ff;
  assign cfg.clamp_sel_off = clamp_sel_off_ff;
  assign cfg.por_mask = por_mask_ff;
  assign cfg.trim = trim_ff;
  assign cfg.core_ret = core_ret_ff;
  assign cfg.low_reg_ctrl = low_reg_ff;
  assign cfg.hi_cmp_on = hi_cmp_ff;
  assign cfg.por_dis = por_dis_ff;
  assign cfg.tie_sw_on = tie_sw_ff;
  assign cfg.conv_on = conv_on_ff;
  assign cfg.conv_sel = conv_sel_ff;

  prmc_rail_decode u_dec (
    .core_clk(core_clk),
    .resetn(resetn),
    .cfg(cfg),
    .mode(power_mode),
    .sys_domain_up(system_domain_up),
    .boost_mode(boost_seen_ff),
    .high_near_low(high_near_low),
    .por_high_raw(por_high_raw),
    .clamp_from_high_ff(clamp_from_high_ff),
    .conv_run_ff(converter_run_ff),
    .conv_level_ff(converter_level_ff),
    .tie_switch_ff(rail_tie_switch_ff),
    .por_reset_ff(por_high_reset_ff),
    .por_status_ff(por_status),
    .por_status_valid_ff(por_status_valid)
  );

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      clamp_trim_ff <= prmc_pkg::TRIM_RST;
      low_regulator_mode_ff <= prmc_pkg::LOW_REG_RST;
      core_retention_ff <= 1'b0;
      high_comparator_ff <= 1'b0;
      boost_mode_ff <= 1'b0;
    end else begin
      clamp_trim_ff <= trim_ff;
      low_regulator_mode_ff <= low_reg_ff;
      core_retention_ff <= core_ret_ff;
      high_comparator_ff <= hi_cmp_ff;
      boost_mode_ff <= boost_seen_ff;
    end
  end
endmodule // prmc_top

// ===== verilog/prmc_pkg.sv
// constants and types for the power rail mode control block
package prmc_pkg;
  // register byte offsets
  localparam logic [7:0] ALWAYS_ON_POWER_CONTROL_OFS = 8'h00;
  localparam logic [7:0] POWER_CONTROL_OFS = 8'h04;
  localparam logic [7:0] CONVERTER_CONTROL_OFS = 8'h08;
  localparam logic [7:0] POWER_LEVEL_OFS = 8'h0C;
  localparam logic [7:0] RAIL_STATUS_OFS = 8'h10;
  // always_on_power_control fields
  localparam int AON_TIE_RES_LSB = 0;
  localparam int AON_CLAMP_SEL_OFF_BIT = 2;
  localparam int AON_POR_MASK_BIT = 3;
  localparam int AON_TRIM_LSB = 4;
  localparam int AON_CORE_RET_BIT = 8;
  // power_control fields
  localparam int PWR_LOW_REG_LSB = 0;
  localparam int PWR_CORE_RET_BIT = 2;
  localparam int PWR_HI_CMP_BIT = 3;
  localparam int PWR_POR_DIS_BIT = 4;
  localparam int PWR_TIE_SW_BIT = 5;
  // converter_control / power_level fields
  localparam int CNV_ON_BIT = 0;
  localparam int LVL_SEL_LSB = 0;
  // reset values and field encodings
  localparam logic [1:0] TIE_RES_DIODE = 2'h0;
  localparam logic [1:0] TIE_RES_FORCE = 2'h1;
  localparam logic [1:0] TIE_RES_SW = 2'h2;
  localparam logic [1:0] TIE_RES_HW = 2'h3;
  localparam logic [3:0] TRIM_RST = 4'hE;
  localparam logic [1:0] LOW_REG_RST = 2'h3;
  localparam logic [1:0] LOW_REG_OFF = 2'h1;
  localparam logic [1:0] LVL_1V8 = 2'h0;
  localparam logic [1:0] LVL_2V5 = 2'h1;
  localparam logic [1:0] LVL_3V0 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PRMC_ACTIVE = 2'b00,
    PRMC_SLEEP = 2'b01,
    PRMC_DEEP = 2'b10,
    PRMC_HIBERN = 2'b11
  } prmc_mode_t;
endpackage

// ===== verilog/prmc_if.sv
// control field bundle between register file and rail decoder
`timescale 1ns/100ps
interface prmc_if;
  logic [1:0] tie_res_ctrl;
  logic clamp_sel_off;
  logic por_mask;
  logic [3:0] trim;
  logic core_ret;
  logic [1:0] low_reg_ctrl;
  logic hi_cmp_on;
  logic por_dis;
  logic tie_sw_on;
  logic conv_on;
  logic [1:0] conv_sel;
  modport regs (output tie_res_ctrl, clamp_sel_off, por_mask, trim, core_ret, low_reg_ctrl,
    hi_cmp_on, por_dis, tie_sw_on, conv_on, conv_sel);
  modport dec (input tie_res_ctrl, clamp_sel_off, por_mask, trim, core_ret, low_reg_ctrl,
    hi_cmp_on, por_dis, tie_sw_on, conv_on, conv_sel);
endinterface

// ===== verilog/prmc_rail_decode.sv
// registered decode of control fields into analog enables
`timescale 1ns/100ps
module prmc_rail_decode (
  input wire logic core_clk,
  input wire logic resetn,
  prmc_if.dec cfg,
  input wire prmc_pkg::prmc_mode_t mode,
  input wire logic sys_domain_up,
  input wire logic boost_mode,
  input wire logic high_near_low,
  input wire logic por_high_raw,
  output logic clamp_from_high_ff,
  output logic conv_run_ff,
  output logic [1:0] conv_level_ff,
  output logic tie_switch_ff,
  output logic por_reset_ff,
  output logic por_status_ff,
  output logic por_status_valid_ff
);
  logic nxt_tie;
  logic sleeping;

  assign sleeping = (mode != prmc_pkg::PRMC_ACTIVE);

  always_comb begin
    nxt_tie = cfg.tie_sw_on;
    case (cfg.tie_res_ctrl)
      prmc_pkg::TIE_RES_FORCE: nxt_tie = 1'b1;
      prmc_pkg::TIE_RES_SW: nxt_tie = nxt_tie | (sleeping & cfg.core_ret);
      prmc_pkg::TIE_RES_HW: nxt_tie = nxt_tie | (sleeping & cfg.core_ret & cfg.hi_cmp_on
        & high_near_low);
      default: nxt_tie = cfg.tie_sw_on; // diode path only
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tie_switch_ff <= 1'b0;
    end else begin
      tie_switch_ff <= nxt_tie;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      clamp_from_high_ff <= 1'b0;
      conv_run_ff <= 1'b0;
      conv_level_ff <= prmc_pkg::LVL_1V8;
    end else begin
      clamp_from_high_ff <= cfg.clamp_sel_off;
      conv_run_ff <= cfg.conv_on & sys_domain_up;
      conv_level_ff <= (boost_mode && cfg.conv_sel == 2'h3) ? prmc_pkg::LVL_3V0
        : cfg.conv_sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      por_reset_ff <= 1'b0;
      por_status_ff <= 1'b0;
      por_status_valid_ff <= 1'b0;
    end else begin
      por_reset_ff <= por_high_raw & ~cfg.por_mask & ~cfg.por_dis;
      por_status_ff <= por_high_raw & ~cfg.por_dis;
      por_status_valid_ff <= ~cfg.por_dis;
    end
  end
endmodule // prmc_rail_decode

// ===== dv/prmc_top_monitor.sv
// concurrent checks on the power rail mode control top ports
`timescale 1ns/100ps
module prmc_top_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic system_domain_up,
  input wire logic boost_detected,
  input wire logic por_high_raw,
  input wire logic [3:0] clamp_trim_ff,
  input wire logic converter_run_ff,
  input wire logic [1:0] converter_level_ff,
  input wire logic [1:0] low_regulator_mode_ff,
  input wire logic rail_tie_switch_ff,
  input wire logic por_high_reset_ff,
  input wire logic boost_mode_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // --------------------------------
  // assertions
  // --------------------------------
  reset_values_a: assert property (disable iff (1'b0)
    !resetn [*2] |-> clamp_trim_ff == 4'hE && low_regulator_mode_ff == 2'h3
    && converter_level_ff == 2'h0 && !rail_tie_switch_ff) else $error("reset values wrong");
  conv_off_a: assert property (!system_domain_up [*3] |-> !converter_run_ff)
    else $error("converter runs with system domain down");
  conv_cause_a: assert property ($rose(converter_run_ff) |-> $past(system_domain_up))
    else $error("converter started without system domain");
  por_cause_a: assert property (por_high_reset_ff |-> $past(por_high_raw))
    else $error("detector reset without a trip");
  boost_follow_a: assert property (boost_detected [*4] |-> boost_mode_ff)
    else $error("boost not identified");
  boost_drop_a: assert property (!boost_detected [*4] |-> !boost_mode_ff)
    else $error("boost shown in buck");
  boost_level_a: assert property (boost_mode_ff [*3] |-> converter_level_ff != 2'h3)
    else $error("boost level out of range");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  // --------------------------------
  // covers
  // --------------------------------
  conv_on_c: cover property ($rose(converter_run_ff));
  por_reset_c: cover property ($rose(por_high_reset_ff));
  tie_on_c: cover property ($rose(rail_tie_switch_ff));
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // prmc_top_monitor

bind prmc_top prmc_top_monitor i_mon (.core_clk, .resetn, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .system_domain_up,
  .boost_detected, .por_high_raw, .clamp_trim_ff, .converter_run_ff, .converter_level_ff,
  .low_regulator_mode_ff, .rail_tie_switch_ff, .por_high_reset_ff, .boost_mode_ff);

// ===== dv/power_rail_mode_control_bench.sv
// self-checking bench for the power rail mode control block
`timescale 1ns/100ps
module power_rail_mode_control_bench;
  logic core_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, clamp_trim_ff;
  logic [1:0] s_axi_bresp, s_axi_rresp, converter_level_ff, low_regulator_mode_ff, rs;
  prmc_pkg::prmc_mode_t power_mode;
  logic system_domain_up, boost_detected, high_near_low, por_high_raw, clamp_from_high_ff;
  logic converter_run_ff, core_retention_ff, high_comparator_ff, rail_tie_switch_ff;
  logic por_high_reset_ff, boost_mode_ff;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  // addr, data, output select, expected
  logic [27:0] rows [14] = '{
    28'h00_0E4_0_1, 28'h00_0A0_1_A,
    28'h04_007_2_3, 28'h04_007_3_1,
    28'h0C_000_5_0, 28'h08_001_6_1,
    28'h04_005_2_1, 28'h0C_001_5_1, 28'h0C_002_5_2,
    28'h04_00C_4_1, 28'h04_020_7_1, 28'h04_000_7_0,
    28'h00_001_7_1, 28'h08_000_6_0};

  prmc_top i_dut (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode, .system_domain_up,
    .boost_detected, .high_near_low, .por_high_raw, .clamp_from_high_ff, .clamp_trim_ff,
    .converter_run_ff, .converter_level_ff, .low_regulator_mode_ff, .core_retention_ff,
    .high_comparator_ff, .rail_tie_switch_ff, .por_high_reset_ff, .boost_mode_ff);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic finish_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] outv(input logic [3:0] s);
    case (s)
      4'h0: return {31'h0, clamp_from_high_ff};
      4'h1: return {28'h0, clamp_trim_ff};
      4'h2: return {30'h0, low_regulator_mode_ff};
      4'h3: return {31'h0, core_retention_ff};
      4'h4: return {31'h0, high_comparator_ff};
      4'h5: return {30'h0, converter_level_ff};
      4'h6: return {31'h0, converter_run_ff};
      4'h7: return {31'h0, rail_tie_switch_ff};
      4'h8: return {31'h0, por_high_reset_ff};
      default: return {31'h0, boost_mode_ff};
    endcase
  endfunction

  // settle three edges, then compare one output
  task automatic expo(input logic [3:0] s, input logic [31:0] e);
    repeat (3) @(posedge core_clk);
    chk($sformatf("output %0d", s), e, outv(s));
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge core_clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge core_clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    // response left waiting a cycle so its hold is exercised
    repeat (2) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    // read data left waiting a cycle so its hold is exercised
    @(posedge core_clk);
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    resetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    power_mode = prmc_pkg::PRMC_ACTIVE;
    system_domain_up = 1'b1;
    boost_detected = 1'b0;
    high_near_low = 1'b0;
    por_high_raw = 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      axw(rows[i][27:20], {20'h0, rows[i][19:8]}, rs);
      chk("write response", 32'h0, {30'h0, rs});
      expo(rows[i][7:4], {28'h0, rows[i][3:0]});
    end
    resetn <= 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    expo(4'h1, 32'hE);
    expo(4'h7, 32'h0);
    axr(prmc_pkg::ALWAYS_ON_POWER_CONTROL_OFS, rd, rs);
    chk("control readback", 32'hE0, rd);
    axw(prmc_pkg::CONVERTER_CONTROL_OFS, 32'h1, rs);
    expo(4'h6, 32'h1);
    system_domain_up <= 1'b0;
    expo(4'h6, 32'h0);
    system_domain_up <= 1'b1;
    expo(4'h6, 32'h1);
    axw(prmc_pkg::ALWAYS_ON_POWER_CONTROL_OFS, 32'h102, rs);
    expo(4'h7, 32'h0);
    power_mode <= prmc_pkg::PRMC_SLEEP;
    expo(4'h7, 32'h1);
    axw(prmc_pkg::ALWAYS_ON_POWER_CONTROL_OFS, 32'h103, rs);
    axw(prmc_pkg::POWER_CONTROL_OFS, 32'h0F, rs);
    expo(4'h7, 32'h0);
    high_near_low <= 1'b1;
    expo(4'h7, 32'h1);
    por_high_raw <= 1'b1;
    expo(4'h8, 32'h1);
    axw(prmc_pkg::ALWAYS_ON_POWER_CONTROL_OFS, 32'h108, rs);
    expo(4'h8, 32'h0);
    axr(prmc_pkg::RAIL_STATUS_OFS, rd, rs);
    chk("detector status", 32'h3, rd & 32'h3);
    axw(prmc_pkg::ALWAYS_ON_POWER_CONTROL_OFS, 32'h100, rs);
    axw(prmc_pkg::POWER_CONTROL_OFS, 32'h1F, rs);
    expo(4'h8, 32'h0);
    axr(prmc_pkg::RAIL_STATUS_OFS, rd, rs);
    chk("detector status", 32'h0, rd & 32'h3);
    boost_detected <= 1'b1;
    axw(prmc_pkg::POWER_LEVEL_OFS, 32'h3, rs);
    expo(4'h9, 32'h1);
    expo(4'h5, 32'h2);
    axr(prmc_pkg::RAIL_STATUS_OFS, rd, rs);
    chk("boost status", 32'h4, rd & 32'h4);
    axw(prmc_pkg::ALWAYS_ON_POWER_CONTROL_OFS, 32'h108, rs);
    axw(prmc_pkg::POWER_CONTROL_OFS, 32'h3, rs);
    expo(4'h8, 32'h0);
    axr(prmc_pkg::RAIL_STATUS_OFS, rd, rs);
    chk("masked status", 32'h7, rd & 32'h7);
    axw(prmc_pkg::RAIL_STATUS_OFS, 32'h0, rs);
    chk("status write response", 32'h0, {30'h0, rs});
    axw(8'h20, 32'hFFFF_FFFF, rs);
    chk("unmapped write response", 32'h2, {30'h0, rs});
    axr(8'h20, rd, rs);
    chk("unmapped read response", 32'h2, {30'h0, rs});
    chk("unmapped read data", 32'h0, rd);
    finish_test();
  end
endmodule // power_rail_mode_control_bench
